// ===== core/config_load_pkg.sv
// constants, types and register map of the parallel configuration loader
// assumes a 50 MHz core clock and a host that drives request, clock and data pins
//
// Notes on behaviour
// - request low drives done low within 600 ns
// - request low drives status low within 600 ns
// - status stays low 268 to 1506 us
// - status released within 1506 us after request high
// - data word captured on config clock rising edge
// - ratio one unless decompression or security on
// - oscillator init: user mode 175 to 437 us
// - user clock init: 8576 user clock periods
package config_load_pkg;

  // core clock
  localparam int CLK_PERIOD_NS      = 20;

  // documented times in their own units
  localparam int REQ_REACT_MAX_NS   = 600;
  localparam int STATUS_LOW_MIN_US  = 268;
  localparam int STATUS_LOW_MAX_US  = 1506;
  localparam int INIT_OSC_MIN_US    = 175;
  localparam int INIT_OSC_MAX_US    = 437;
  localparam int USER_INIT_PERIODS  = 8576;

  // derived cycle counts: least times round up, longest round down
  localparam int REQ_REACT_MAX_CYC  = REQ_REACT_MAX_NS / CLK_PERIOD_NS;
  localparam int STATUS_LOW_MIN_CYC = (STATUS_LOW_MIN_US * 1000 + CLK_PERIOD_NS - 1)
                                      / CLK_PERIOD_NS;
  localparam int STATUS_LOW_MAX_CYC = (STATUS_LOW_MAX_US * 1000) / CLK_PERIOD_NS;
  localparam int INIT_OSC_MIN_CYC   = (INIT_OSC_MIN_US * 1000 + CLK_PERIOD_NS - 1)
                                      / CLK_PERIOD_NS;
  localparam int INIT_OSC_MAX_CYC   = (INIT_OSC_MAX_US * 1000) / CLK_PERIOD_NS;

  // widths
  localparam int TIMER_W            = 17;
  localparam int DATA_W             = 32;
  localparam int ADDR_W             = 4;
  localparam int COUNT_W            = 24;
  localparam int RATIO_W            = 4;
  localparam int FIFO_DEPTH         = 8;

  // register byte offsets
  localparam logic [ADDR_W-1:0] REG_CONTROL    = 4'h0;
  localparam logic [ADDR_W-1:0] REG_LOAD_WORDS = 4'h4;
  localparam logic [ADDR_W-1:0] REG_STATUS     = 4'h8;
  localparam logic [ADDR_W-1:0] REG_WORD_COUNT = 4'hC;

  // control field positions
  localparam int CTL_WIDTH_LSB      = 0;
  localparam int CTL_DECOMP_BIT     = 2;
  localparam int CTL_SECURE_BIT     = 3;
  localparam int CTL_USER_CLK_BIT   = 4;
  localparam int CTL_RATIO_LSB      = 8;

  // status field positions
  localparam int STS_STATE_LSB      = 0;
  localparam int STS_DONE_BIT       = 3;
  localparam int STS_USER_BIT       = 4;
  localparam int STS_FAULT_BIT      = 5;
  localparam int STS_LINE_BIT       = 6;

  // reset values
  localparam logic [1:0]         WIDTH_RESET = 2'h2;
  localparam logic [RATIO_W-1:0] RATIO_RESET = 4'h1;
  localparam logic [RATIO_W-1:0] RATIO_MIN_SECURE = 4'h2;
  localparam logic [COUNT_W-1:0] LOAD_WORDS_RESET = 24'h000000;

  typedef enum logic [1:0] {
    BUS_X8  = 2'h0,
    BUS_X16 = 2'h1,
    BUS_X32 = 2'h2
  } bus_width_t;

  // gray along clear, load, init, user
  typedef enum logic [2:0] {
    ST_CLEAR = 3'h0,
    ST_LOAD  = 3'h1,
    ST_INIT  = 3'h3,
    ST_USER  = 3'h2,
    ST_FAULT = 3'h6
  } load_state_t;

  typedef struct packed {
    logic [DATA_W-1:0] data;
    bus_width_t        width;
  } config_word_t;

endpackage

// ===== core/word_fifo.sv
// generic flip-flop FIFO with valid and ready on both sides
// assumes one clock and a synchronous active-high reset
`timescale 1ns/1ps
`default_nettype none
module word_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // clock and reset
  input  wire logic             core_clk,
  input  wire logic             rst,
  // filling side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // draining side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);

  localparam int PTR_W = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PTR_W-1:0] wr_ptr;
  logic [PTR_W-1:0] rd_ptr;
  logic [PTR_W:0]   fill;
  logic             push;
  logic             pop;

  assign in_ready  = (fill != (PTR_W+1)'(DEPTH));
  assign out_valid = (fill != '0);
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  assign out_data  = mem[rd_ptr];

  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      fill   <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == PTR_W'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == PTR_W'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      fill <= fill + (PTR_W+1)'(push) - (PTR_W+1)'(pop);
    end
  end

endmodule
`default_nettype wire

// ===== core/parallel_config_load.sv
// device side of the fast parallel configuration load sequence
// assumes host pins arrive asynchronously, status is an open-drain line and
// captured words are drained by the configuration memory over word_valid/word_ready
`timescale 1ns/1ps
`default_nettype none
module parallel_config_load #(
  parameter int STATUS_LOW_CYCLES = config_load_pkg::STATUS_LOW_MIN_CYC,
  parameter int INIT_OSC_CYCLES   = config_load_pkg::INIT_OSC_MIN_CYC,
  parameter int USER_INIT_EDGES   = config_load_pkg::USER_INIT_PERIODS
) (
  // clock and reset
  input  wire logic                                  core_clk,
  input  wire logic                                  rst,
  // register port
  input  wire logic [config_load_pkg::ADDR_W-1:0]    reg_addr,
  input  wire logic [config_load_pkg::DATA_W-1:0]    reg_wdata,
  input  wire logic                                  reg_write,
  input  wire logic                                  reg_read,
  output logic [config_load_pkg::DATA_W-1:0]         reg_rdata,
  // host pins
  input  wire logic                                  config_request_n,
  input  wire logic                                  config_clock,
  input  wire logic [config_load_pkg::DATA_W-1:0]    config_data,
  input  wire logic                                  user_init_clock,
  // open-drain status line
  input  wire logic                                  config_status_n_in,
  output logic                                       config_status_n_out,
  output logic                                       config_status_n_oe_n,
  // done and user mode
  output logic                                       config_done,
  output logic                                       user_mode,
  // captured words toward configuration memory
  output logic                                       word_valid,
  input  wire logic                                  word_ready,
  output config_load_pkg::config_word_t              word_out
);

  import config_load_pkg::*;

  localparam int PIN_W = 4 + DATA_W;

  // pin synchronisers
  logic [PIN_W-1:0]   pins_meta;
  logic [PIN_W-1:0]   pins_sync;
  logic               clk_pin_d;
  logic               uclk_pin_d;

  logic               req_low;
  logic               line_high;
  logic               config_clock_rise;
  logic               uclk_rise;
  logic [DATA_W-1:0]  data_sync;

  // registers
  bus_width_t         bus_width;
  logic               decomp_en;
  logic               secure_en;
  logic               user_clk_opt;
  logic [RATIO_W-1:0] ratio;
  logic [COUNT_W-1:0] load_words;
  logic [COUNT_W-1:0] word_count;
  logic               fault;

  // sequencing
  load_state_t        state;
  load_state_t        next_state;
  logic [TIMER_W-1:0] timer;
  logic [RATIO_W-1:0] phase;
  logic [RATIO_W-1:0] ratio_eff;
  logic               capture;
  logic               overflow;
  logic               load_complete;
  logic               init_complete;
  logic               hold_status;

  // fifo
  config_word_t       push_word;
  logic               push_ready;
  logic               fifo_empty_n;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      // request idles high, so reset must not look like a fresh request
      pins_meta <= {1'b1, {(PIN_W-1){1'b0}}};
      pins_sync <= {1'b1, {(PIN_W-1){1'b0}}};
    end else begin
      pins_meta <= {config_request_n, config_status_n_in, config_clock,
                    user_init_clock, config_data};
      pins_sync <= pins_meta;
    end
  end

  assign req_low   = ~pins_sync[PIN_W-1];
  assign line_high = pins_sync[PIN_W-2];
  assign data_sync = pins_sync[DATA_W-1:0];

  always_ff @(posedge core_clk) begin
    if (rst) begin
      clk_pin_d  <= 1'b0;
      uclk_pin_d <= 1'b0;
    end else begin
      clk_pin_d  <= pins_sync[PIN_W-3];
      uclk_pin_d <= pins_sync[PIN_W-4];
    end
  end

  assign config_clock_rise = pins_sync[PIN_W-3] & ~clk_pin_d;
  assign uclk_rise = pins_sync[PIN_W-4] & ~uclk_pin_d;

  // register writes
  always_ff @(posedge core_clk) begin
    if (rst) begin
      bus_width    <= bus_width_t'(WIDTH_RESET);
      decomp_en    <= 1'b0;
      secure_en    <= 1'b0;
      user_clk_opt <= 1'b0;
      ratio        <= RATIO_RESET;
      load_words   <= LOAD_WORDS_RESET;
    end else if (reg_write) begin
      case (reg_addr)
        REG_CONTROL: begin
          bus_width    <= bus_width_t'(reg_wdata[CTL_WIDTH_LSB +: 2]);
          decomp_en    <= reg_wdata[CTL_DECOMP_BIT];
          secure_en    <= reg_wdata[CTL_SECURE_BIT];
          user_clk_opt <= reg_wdata[CTL_USER_CLK_BIT];
          ratio        <= reg_wdata[CTL_RATIO_LSB +: RATIO_W];
        end
        REG_LOAD_WORDS: begin
          load_words <= reg_wdata[COUNT_W-1:0];
        end
        default: begin
        end
      endcase
    end
  end

  // read data stand only in the cycle after the strobe
  always_ff @(posedge core_clk) begin
    if (rst) begin
      reg_rdata <= '0;
    end else if (reg_read) begin
      case (reg_addr)
        REG_CONTROL: begin
          reg_rdata <= DATA_W'({ratio, 3'h0, user_clk_opt, secure_en, decomp_en,
                                2'(bus_width)});
        end
        REG_LOAD_WORDS: begin
          reg_rdata <= DATA_W'(load_words);
        end
        REG_STATUS: begin
          reg_rdata <= DATA_W'({line_high, fault, user_mode, config_done, 3'(state)});
        end
        REG_WORD_COUNT: begin
          reg_rdata <= DATA_W'(word_count);
        end
        default: begin
          reg_rdata <= '0;
        end
      endcase
    end else begin
      reg_rdata <= '0;
    end
  end

  // ratio is forced to one with both features off, at least two otherwise
  always_comb begin
    if (!(decomp_en | secure_en)) begin
      ratio_eff = RATIO_W'(1);
    end else if (ratio < RATIO_MIN_SECURE) begin
      ratio_eff = RATIO_MIN_SECURE;
    end else begin
      ratio_eff = ratio;
    end
  end

  // one word per ratio_eff rising edges; the host holds it in between
  assign capture  = (state == ST_LOAD) & config_clock_rise & (phase == '0)
                    & (word_count != load_words);
  assign overflow = capture & ~push_ready;

  always_comb begin
    push_word.width = bus_width;
    case (bus_width)
      BUS_X8:  push_word.data = {24'h000000, data_sync[7:0]};
      BUS_X16: push_word.data = {16'h0000, data_sync[15:0]};
      default: push_word.data = data_sync;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst || req_low || state != ST_LOAD) begin
      phase <= '0;
    end else if (config_clock_rise) begin
      phase <= (phase + 1'b1 == ratio_eff) ? '0 : phase + 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst || req_low) begin
      word_count <= '0;
    end else if (capture && push_ready) begin
      word_count <= word_count + 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst || req_low) begin
      fault <= 1'b0;
    end else if (overflow || (state == ST_LOAD && !line_high)) begin
      fault <= 1'b1;
    end
  end

  assign load_complete = (word_count == load_words) & ~fifo_empty_n;
  assign init_complete = user_clk_opt ? (timer >= TIMER_W'(USER_INIT_EDGES))
                                      : (timer >= TIMER_W'(INIT_OSC_CYCLES));

  always_comb begin
    next_state = state;
    case (state)
      ST_CLEAR: begin
        if (!req_low && timer >= TIMER_W'(STATUS_LOW_CYCLES) && line_high) begin
          next_state = ST_LOAD;
        end
      end
      ST_LOAD: begin
        if (overflow || !line_high) begin
          next_state = ST_FAULT;
        end else if (load_complete) begin
          next_state = ST_INIT;
        end
      end
      ST_INIT: begin
        if (init_complete) begin
          next_state = ST_USER;
        end
      end
      ST_USER: begin
        next_state = ST_USER;
      end
      ST_FAULT: begin
        next_state = ST_FAULT;
      end
      default: begin
        next_state = ST_CLEAR;
      end
    endcase
    if (req_low) begin
      next_state = ST_CLEAR;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state <= ST_CLEAR;
    end else begin
      state <= next_state;
    end
  end

  // status low time counts from the last cycle the request was seen low
  always_ff @(posedge core_clk) begin
    if (rst || req_low || state != next_state) begin
      timer <= '0;
    end else if (timer != '1) begin
      case (state)
        ST_CLEAR: timer <= timer + 1'b1;
        ST_INIT:  timer <= (user_clk_opt && !uclk_rise) ? timer : timer + 1'b1;
        default:  timer <= timer;
      endcase
    end
  end

  // status held low while clearing or after a fault; extended by the request
  assign hold_status = (state == ST_CLEAR && (req_low || timer < TIMER_W'(STATUS_LOW_CYCLES)))
                       || state == ST_FAULT;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      config_status_n_oe_n <= 1'b0;
    end else begin
      config_status_n_oe_n <= ~(hold_status | (req_low & ~rst));
    end
  end

  assign config_status_n_out = 1'b0;

  always_ff @(posedge core_clk) begin
    if (rst || req_low) begin
      config_done <= 1'b0;
    end else begin
      config_done <= (next_state == ST_INIT) || (next_state == ST_USER);
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst || req_low) begin
      user_mode <= 1'b0;
    end else begin
      user_mode <= (next_state == ST_USER);
    end
  end

  word_fifo #(
    .WIDTH ($bits(config_word_t)),
    .DEPTH (FIFO_DEPTH)
  ) i_word_fifo (
    .core_clk  (core_clk),
    .rst       (rst | req_low),
    .in_valid  (capture),
    .in_ready  (push_ready),
    .in_data   (push_word),
    .out_valid (fifo_empty_n),
    .out_ready (word_ready),
    .out_data  (word_out)
  );

  assign word_valid = fifo_empty_n;

endmodule
`default_nettype wire

// ===== testbench/parallel_config_load_props.sv
// concurrent checks on the pins of the parallel configuration loader
// assumes it is bound to parallel_config_load and sees only its ports
`timescale 1ns/1ps
`default_nettype none
module parallel_config_load_props #(
  parameter int STATUS_LOW_CYCLES = 20,
  parameter int INIT_OSC_CYCLES   = 20
) (
  // clock and reset
  input wire logic                          core_clk,
  input wire logic                          rst,
  // host pins and status line
  input wire logic                          config_request_n,
  input wire logic                          config_status_n_out,
  input wire logic                          config_status_n_oe_n,
  // done and user mode
  input wire logic                          config_done,
  input wire logic                          user_mode,
  // word stream
  input wire logic                          word_valid,
  input wire logic                          word_ready,
  input wire config_load_pkg::config_word_t word_out
);
  import config_load_pkg::*;
  localparam int LOW_MAX  = STATUS_LOW_CYCLES + 6;
  localparam int INIT_MIN = INIT_OSC_CYCLES - 2;
  int low_cnt;
  int init_cnt;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  // cycles the device has pulled status low
  always_ff @(posedge core_clk) begin
    if (rst || config_status_n_oe_n) low_cnt <= 0;
    else low_cnt <= low_cnt + 1;
  end
  // cycles spent between done and user mode
  always_ff @(posedge core_clk) begin
    if (rst || !config_done || user_mode) init_cnt <= 0;
    else init_cnt <= init_cnt + 1;
  end
  property p_done_low;
    $fell(config_request_n) |-> ##[1:4] !config_done;
  endproperty
  a_done_low: assert property (p_done_low)
    else $error("done not low after request");
  property p_status_low;
    $fell(config_request_n) |-> ##[1:4] !config_status_n_oe_n;
  endproperty
  a_status_low: assert property (p_status_low)
    else $error("status not pulled low after request");
  property p_drive_zero;
    !config_status_n_oe_n |-> !config_status_n_out;
  endproperty
  a_drive_zero: assert property (p_drive_zero)
    else $error("status driven to a high level");
  property p_abort;
    !config_request_n [*4] |-> !config_done && !user_mode && !config_status_n_oe_n;
  endproperty
  a_abort: assert property (p_abort)
    else $error("held request did not restart the load");
  property p_low_min;
    $rose(config_status_n_oe_n) |-> low_cnt >= STATUS_LOW_CYCLES;
  endproperty
  a_low_min: assert property (p_low_min)
    else $error("status low pulse too short");
  property p_low_max;
    $rose(config_request_n) |-> ##[1:LOW_MAX] config_status_n_oe_n;
  endproperty
  a_low_max: assert property (p_low_max)
    else $error("status not released in time");
  property p_user_done;
    user_mode |-> config_done;
  endproperty
  a_user_done: assert property (p_user_done)
    else $error("user mode without done");
  property p_init_min;
    $rose(user_mode) |-> init_cnt >= INIT_MIN;
  endproperty
  a_init_min: assert property (p_init_min)
    else $error("user mode entered too early");
  property p_word_hold;
    word_valid && !word_ready |=> word_valid && $stable(word_out);
  endproperty
  a_word_hold: assert property (p_word_hold)
    else $error("stalled word changed");
endmodule

bind parallel_config_load parallel_config_load_props #(
  .STATUS_LOW_CYCLES(STATUS_LOW_CYCLES),
  .INIT_OSC_CYCLES  (INIT_OSC_CYCLES)
) i_parallel_config_load_props (
  .core_clk            (core_clk),
  .rst                 (rst),
  .config_request_n    (config_request_n),
  .config_status_n_out (config_status_n_out),
  .config_status_n_oe_n(config_status_n_oe_n),
  .config_done         (config_done),
  .user_mode           (user_mode),
  .word_valid          (word_valid),
  .word_ready          (word_ready),
  .word_out            (word_out)
);
`default_nettype wire

// ===== testbench/config_host.sv
// behavioural configuration host driving request, clock and data pins
// assumes the bench resolves the open-drain status line onto status_n
`timescale 1ns/1ps
`default_nettype none
module config_host (
  // resolved status line
  input wire logic                                status_n,
  // host pins
  output logic                                    config_request_n,
  output logic                                    config_clock,
  output logic [config_load_pkg::DATA_W-1:0]      config_data,
  output logic                                    user_init_clock
);
  import config_load_pkg::*;
  initial begin
    config_request_n = 1'b1;
    config_clock = 1'b0;
    config_data = 32'h00000000;
    user_init_clock = 1'b0;
  end
  // request pulse, then wait for status release
  task automatic restart();
    #3;
    config_request_n = 1'b0;
    config_data = ~config_data;
    #2200;
    config_request_n = 1'b1;
    wait (status_n === 1'b1);
    #2003;
  endtask
  // one word held for r clock periods, inverted once its hold is over
  task automatic send(input logic [DATA_W-1:0] w, input int r);
    #20 config_data = w;
    repeat (r) begin
      #80 config_clock = 1'b1;
      #80 config_clock = 1'b0;
    end
    config_data = ~w;
  endtask
  task automatic uclk(input int n);
    #3;
    repeat (n) begin
      #80 user_init_clock = 1'b1;
      #80 user_init_clock = 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// ===== testbench/parallel_config_load_tb.sv
// self-checking bench for the parallel configuration loader
// assumes config_host as the far side and the bound checker
`timescale 1ns/1ps
`default_nettype none
module parallel_config_load_tb;
  import config_load_pkg::*;
  localparam int USER_EDGES = 8;
  logic              core_clk = 1'b0;
  logic              rst = 1'b1;
  logic [ADDR_W-1:0] reg_addr = 4'h0;
  logic [DATA_W-1:0] reg_wdata = 32'h00000000;
  logic              reg_write = 1'b0;
  logic              reg_read = 1'b0;
  logic [DATA_W-1:0] reg_rdata;
  wire               config_request_n;
  wire               config_clock;
  wire  [DATA_W-1:0] config_data;
  wire               user_init_clock;
  wire               status_line;
  logic              status_out;
  logic              status_oe_n;
  logic              config_done;
  logic              user_mode;
  logic              word_valid;
  logic              word_ready = 1'b1;
  config_word_t      word_out;
  config_word_t      exp_w[$];
  logic [DATA_W-1:0] exp_r[$];
  logic [DATA_W-1:0] seed = 32'h00000061;
  logic [DATA_W-1:0] ctl[3] = '{32'h00000304, 32'h00000019, 32'h00000502};
  logic [DATA_W-1:0] m[3] = '{32'h000000FF, 32'h0000FFFF, 32'hFFFFFFFF};
  int                nr[3] = '{3, 2, 1};
  int                n_errors = 0;
  int                n_tests = 0;
  int                cyc = 0;
  logic              rd_d = 1'b0;
  // pull-up on the open-drain status line
  assign status_line = status_oe_n ? 1'b1 : status_out;
  always #10 core_clk = ~core_clk;
  parallel_config_load #(
    .STATUS_LOW_CYCLES(20),
    .INIT_OSC_CYCLES  (20),
    .USER_INIT_EDGES  (USER_EDGES)
  ) i_parallel_config_load (
    .core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .config_request_n(config_request_n), .config_clock(config_clock),
    .config_data(config_data), .user_init_clock(user_init_clock),
    .config_status_n_in(status_line), .config_status_n_out(status_out),
    .config_status_n_oe_n(status_oe_n), .config_done(config_done),
    .user_mode(user_mode), .word_valid(word_valid), .word_ready(word_ready),
    .word_out(word_out)
  );
  config_host i_config_host (
    .status_n(status_line), .config_request_n(config_request_n),
    .config_clock(config_clock), .config_data(config_data),
    .user_init_clock(user_init_clock)
  );
  function automatic logic [DATA_W-1:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic check(input logic [33:0] seen, input logic [33:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %0t ns: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge core_clk);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_write <= 1'b0;
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    exp_r.push_back(e);
    @(posedge core_clk);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_read <= 1'b0;
  endtask
  // n random words, the first keep of them expected at the sink
  task automatic words(input int n, input int r, input int k, input int keep);
    logic [DATA_W-1:0] w;
    for (int i = 0; i < n; i++) begin
      w = xs();
      if (i < keep)
        exp_w.push_back({w & m[k], bus_width_t'(k)});
      i_config_host.send(w, r);
    end
  endtask
  task automatic give_verdict();
    $display("comparisons %0d, mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge core_clk) begin
    if (rd_d)
      check(reg_rdata, exp_r.pop_front());
    rd_d = reg_read;
    if (word_valid === 1'b1 && word_ready) begin
      if (exp_w.size() == 0)
        check(word_out, ~word_out);
      else
        check(word_out, exp_w.pop_front());
    end
  end
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 10000) begin
      n_errors++;
      give_verdict();
    end
  end
  initial begin
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    rd(REG_STATUS, 32'h00000000);
    wr(REG_STATUS, 32'hFFFFFFFF);
    rd(REG_CONTROL, {20'h0, RATIO_RESET, 6'h0, WIDTH_RESET});
    rd(REG_LOAD_WORDS, {8'h0, LOAD_WORDS_RESET});
    rd(4'h2, 32'h00000000);
    $display("test 1 done");
    for (int k = 0; k < 3; k++) begin
      wr(REG_CONTROL, ctl[k]);
      wr(REG_LOAD_WORDS, 32'h00000004);
      i_config_host.restart();
      words(4, nr[k], k, 4);
      wait (config_done === 1'b1);
      repeat ((k == 1) ? 33 : 1) @(posedge core_clk);
      check(user_mode, 1'b0);
      if (k == 1)
        i_config_host.uclk(USER_EDGES);
      wait (user_mode === 1'b1);
      rd(REG_WORD_COUNT, 32'h00000004);
      $display("test 2.%0d done", k);
    end
    // stalled sink: the ninth capture overruns the buffer
    wr(REG_CONTROL, 32'h00000002);
    wr(REG_LOAD_WORDS, 32'h00000009);
    word_ready <= 1'b0;
    i_config_host.restart();
    words(9, 1, 2, 8);
    repeat (8) @(posedge core_clk);
    check(status_oe_n, 1'b0);
    rd(REG_STATUS, 32'h00000026);
    word_ready <= 1'b1;
    while (exp_w.size() != 0) @(posedge core_clk);
    $display("test 3 done");
    // a second request in mid-load restarts the count
    wr(REG_LOAD_WORDS, 32'h00000004);
    i_config_host.restart();
    words(2, 1, 2, 2);
    i_config_host.restart();
    words(4, 1, 2, 4);
    wait (user_mode === 1'b1);
    rd(REG_WORD_COUNT, 32'h00000004);
    rd(REG_STATUS, 32'h0000005A);
    repeat (3) @(posedge core_clk);
    $display("test 4 done");
    give_verdict();
  end
endmodule
`default_nettype wire
